/* File: core/lofr_map.svh */
// Register indices, field positions and reset values of the LVDS format and routing block.
`ifndef LOFR_MAP_SVH
`define LOFR_MAP_SVH

`define LOFR_IDX_MODE        10'h010
`define LOFR_IDX_FORMAT      10'h018
`define LOFR_IDX_LEVEL       10'h019
`define LOFR_IDX_SWAP        10'h01A
`define LOFR_IDX_TRIM        10'h01B

`define LOFR_MODE_LSB        5
`define LOFR_CHA_LANE_EN_BIT 3
`define LOFR_CHB_LANE_EN_BIT 2
`define LOFR_CHA_LSB_BIT     1
`define LOFR_CHB_LSB_BIT     0
`define LOFR_CHA_CM_BIT      6
`define LOFR_CHB_CM_BIT      4
`define LOFR_CHA_SWING_LSB   2
`define LOFR_CHB_SWING_LSB   0
`define LOFR_SWAP_BIT        6
`define LOFR_CHA_TRIM_LSB    4
`define LOFR_CHB_TRIM_LSB    0

`define LOFR_MODE_DUAL       2'h0
`define LOFR_MODE_SINGLE     2'h1
`define LOFR_MODE_TWO_STREAM 2'h2

`define LOFR_RST_MODE        2'h1
`define LOFR_RST_FORMAT      4'h0
`define LOFR_RST_SWING       2'h1
`define LOFR_RST_TRIM        2'h0

`define LOFR_RESP_OKAY       2'h0
`define LOFR_RESP_SLVERR     2'h2

`endif

/* File: core/lofr_pkg.sv */
// Types shared by the LVDS format and routing block.
package lofr_pkg;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } lofr_pixel_s;

    typedef struct packed {
        logic        valid;
        logic [17:0] mainLanes;
        logic [5:0]  fourthLane;
    } lofr_lanes_s;
endpackage : lofr_pkg

/* File: core/lofr_lane_mapper.sv */
// Splits one 24-bit pixel over the three main lanes and the fourth lane of a channel.
`timescale 1ns/1ps
`default_nettype none
module lofr_lane_mapper (
    input  wire logic                 lsbSelect,
    input  wire logic                 fourthLaneEnable,
    input  wire lofr_pkg::lofr_pixel_s pixel,
    output logic [17:0]               mainLanes,
    output logic [5:0]                fourthLane
);
    import lofr_pkg::*;

    wire [17:0] upperSix = {pixel.red[7:2], pixel.green[7:2], pixel.blue[7:2]};
    wire [17:0] lowerSix = {pixel.red[5:0], pixel.green[5:0], pixel.blue[5:0]};
    wire [5:0]  topPairs = {pixel.red[7:6], pixel.green[7:6], pixel.blue[7:6]};
    wire [5:0]  lowPairs = {pixel.red[1:0], pixel.green[1:0], pixel.blue[1:0]};

    // With the LSB format the main lanes keep the upper six bits, so a disabled
    // fourth lane leaves a clean 18bpp pixel with the two LSBs dropped.
    assign mainLanes  = lsbSelect ? upperSix : lowerSix;
    assign fourthLane = !fourthLaneEnable ? 6'h00 :
                        (lsbSelect ? lowPairs : topPairs);
endmodule : lofr_lane_mapper
`default_nettype wire

/* File: core/lofr_top.sv */
// LVDS output format selection, 18bpp reduction, pixel routing and level registers.
// Behaviour
// - Channel A fourth lane carries colour MSB pairs when select is 0, LSB pairs when 1.
// - Channel B fourth lane carries colour MSB pairs when select is 0, LSB pairs when 1.
// - Select 1 with fourth lane off gives 18bpp output, dropping two LSBs per colour.
// - One common-mode bit per channel, reset 0; 0 means 1.2V, 1 means 0.9V.
// - Two-bit swing select per channel, A at 3:2, B at 1:0, both reset 01.
// - In dual mode swap 0 routes odd pixels to channel A; swap 1 routes them to B.
// - In two-stream mode swap crosses input streams onto the opposite LVDS channels.
// - Fourth lane enable 0 forces 18bpp with lane off; 1 enables 24bpp lane.
// - Mode 00 dual, 01 single at reset, 10 two streams, 11 reserved.
`include "lofr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lofr_top (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire lofr_pkg::lofr_pixel_s inPixelA,
    input  wire logic                  inValidA,
    input  wire lofr_pkg::lofr_pixel_s inPixelB,
    input  wire logic                  inValidB,
    output lofr_pkg::lofr_lanes_s      outLanesA,
    output lofr_pkg::lofr_lanes_s      outLanesB,
    output logic                       cha_common_mode_select,
    output logic                       chb_common_mode_select,
    output logic [1:0]                 cha_swing_select,
    output logic [1:0]                 chb_swing_select,
    output logic [1:0]                 cha_common_mode_trim,
    output logic [1:0]                 chb_common_mode_trim
);
    import lofr_pkg::*;

    logic [1:0]  channelMode;
    logic [3:0]  formatBits;
    logic [7:0]  levelBits;
    logic        pixelSwap;
    logic [7:0]  trimBits;
    logic        awHeld;
    logic [9:0]  awIndex;
    logic        awAligned;
    logic        wHeld;
    logic [7:0]  wByte;
    logic        wLane0;

    // Register write path: address and data may arrive in either order.
    wire doWrite   = awHeld && wHeld && !s_axi_bvalid;
    wire wrMapped  = awAligned && (awIndex == `LOFR_IDX_MODE || awIndex == `LOFR_IDX_FORMAT ||
                     awIndex == `LOFR_IDX_LEVEL || awIndex == `LOFR_IDX_SWAP ||
                     awIndex == `LOFR_IDX_TRIM);
    wire wrEnable  = doWrite && wrMapped && wLane0;
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            awHeld    <= 1'b0;
            awIndex   <= 10'h000;
            awAligned <= 1'b0;
            wHeld     <= 1'b0;
            wByte     <= 8'h00;
            wLane0    <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld    <= 1'b1;
                awIndex   <= s_axi_awaddr[11:2];
                awAligned <= (s_axi_awaddr[1:0] == 2'h0);
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld  <= 1'b1;
                wByte  <= s_axi_wdata[7:0];
                wLane0 <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LOFR_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? `LOFR_RESP_OKAY : `LOFR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Reserved bits are never stored, so they read back as zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            channelMode <= `LOFR_RST_MODE;
            formatBits  <= `LOFR_RST_FORMAT;
            levelBits   <= {4'h0, `LOFR_RST_SWING, `LOFR_RST_SWING};
            pixelSwap   <= 1'b0;
            trimBits    <= {2'h0, `LOFR_RST_TRIM, 2'h0, `LOFR_RST_TRIM};
        end else if (wrEnable) begin
            case (awIndex)
                `LOFR_IDX_MODE:   channelMode <= wByte[`LOFR_MODE_LSB +: 2];
                `LOFR_IDX_FORMAT: formatBits  <= wByte[3:0];
                `LOFR_IDX_LEVEL:  levelBits   <= wByte & 8'h5F;
                `LOFR_IDX_SWAP:   pixelSwap   <= wByte[`LOFR_SWAP_BIT];
                `LOFR_IDX_TRIM:   trimBits    <= wByte & 8'h33;
                default:          trimBits    <= trimBits;
            endcase
        end
    end

    // Register read path.
    wire [9:0] rdIndex   = s_axi_araddr[11:2];
    wire       rdAligned = (s_axi_araddr[1:0] == 2'h0);
    wire [7:0] rdMode    = {1'b0, channelMode, 5'h00};
    wire [7:0] rdSwap    = {1'b0, pixelSwap, 6'h00};
    wire       rdHit     = rdAligned && (rdIndex == `LOFR_IDX_MODE ||
                           rdIndex == `LOFR_IDX_FORMAT || rdIndex == `LOFR_IDX_LEVEL ||
                           rdIndex == `LOFR_IDX_SWAP || rdIndex == `LOFR_IDX_TRIM);
    wire [7:0] rdByte    = !rdAligned ? 8'h00 :
                           (rdIndex == `LOFR_IDX_MODE)   ? rdMode :
                           (rdIndex == `LOFR_IDX_FORMAT) ? {4'h0, formatBits} :
                           (rdIndex == `LOFR_IDX_LEVEL)  ? levelBits :
                           (rdIndex == `LOFR_IDX_SWAP)   ? rdSwap :
                           (rdIndex == `LOFR_IDX_TRIM)   ? trimBits : 8'h00;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `LOFR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
            s_axi_rresp  <= rdHit ? `LOFR_RESP_OKAY : `LOFR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Field decode.
    wire cha_fourth_lane_enable = formatBits[`LOFR_CHA_LANE_EN_BIT];
    wire chb_fourth_lane_enable = formatBits[`LOFR_CHB_LANE_EN_BIT];
    wire cha_lsb_lane_select    = formatBits[`LOFR_CHA_LSB_BIT];
    wire chb_lsb_lane_select    = formatBits[`LOFR_CHB_LSB_BIT];
    assign cha_common_mode_select = levelBits[`LOFR_CHA_CM_BIT];
    assign chb_common_mode_select = levelBits[`LOFR_CHB_CM_BIT];
    assign cha_swing_select       = levelBits[`LOFR_CHA_SWING_LSB +: 2];
    assign chb_swing_select       = levelBits[`LOFR_CHB_SWING_LSB +: 2];
    // Trim is only stored; software must program it before lowering the common mode.
    assign cha_common_mode_trim   = trimBits[`LOFR_CHA_TRIM_LSB +: 2];
    assign chb_common_mode_trim   = trimBits[`LOFR_CHB_TRIM_LSB +: 2];

    // Routing. The reserved mode behaves like single channel so channel B stays idle.
    wire         bothInputs = (channelMode == `LOFR_MODE_DUAL) ||
                              (channelMode == `LOFR_MODE_TWO_STREAM);
    wire         crossed    = bothInputs && pixelSwap;
    lofr_pixel_s srcPixelA;
    lofr_pixel_s srcPixelB;
    assign srcPixelA = crossed ? inPixelB : inPixelA;
    assign srcPixelB = crossed ? inPixelA : inPixelB;
    wire srcValidA   = crossed ? inValidB : inValidA;
    wire srcValidB   = bothInputs && (crossed ? inValidA : inValidB);

    logic [17:0] mainA;
    logic [17:0] mainB;
    logic [5:0]  fourthA;
    logic [5:0]  fourthB;

    lofr_lane_mapper mapA (
        .lsbSelect        (cha_lsb_lane_select),
        .fourthLaneEnable (cha_fourth_lane_enable),
        .pixel            (srcPixelA),
        .mainLanes        (mainA),
        .fourthLane       (fourthA)
    );

    lofr_lane_mapper mapB (
        .lsbSelect        (chb_lsb_lane_select),
        .fourthLaneEnable (chb_fourth_lane_enable),
        .pixel            (srcPixelB),
        .mainLanes        (mainB),
        .fourthLane       (fourthB)
    );

    // One register stage; idle lanes are zeroed so the panel never sees stale data.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outLanesA <= '0;
            outLanesB <= '0;
        end else begin
            outLanesA <= srcValidA ? {1'b1, mainA, fourthA} : '0;
            outLanesB <= srcValidB ? {1'b1, mainB, fourthB} : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_cha_lane_format: assert property (srcValidA && cha_fourth_lane_enable |=>
        outLanesA.fourthLane == ($past(cha_lsb_lane_select) ?
        {$past(srcPixelA.red[1:0]), $past(srcPixelA.green[1:0]), $past(srcPixelA.blue[1:0])} :
        {$past(srcPixelA.red[7:6]), $past(srcPixelA.green[7:6]), $past(srcPixelA.blue[7:6])}))
        else $error("Channel A fourth lane carries the wrong bit pairs.");
    a_chb_lane_format: assert property (srcValidB && chb_fourth_lane_enable |=>
        outLanesB.fourthLane == ($past(chb_lsb_lane_select) ?
        {$past(srcPixelB.red[1:0]), $past(srcPixelB.green[1:0]), $past(srcPixelB.blue[1:0])} :
        {$past(srcPixelB.red[7:6]), $past(srcPixelB.green[7:6]), $past(srcPixelB.blue[7:6])}))
        else $error("Channel B fourth lane carries the wrong bit pairs.");
    a_reduce_to_18: assert property (srcValidA && cha_lsb_lane_select &&
        !cha_fourth_lane_enable |=> outLanesA.mainLanes ==
        {$past(srcPixelA.red[7:2]), $past(srcPixelA.green[7:2]), $past(srcPixelA.blue[7:2])})
        else $error("Reduced pixel does not keep the six upper bits.");
    a_lane_disabled: assert property (!$past(chb_fourth_lane_enable) |->
        outLanesB.fourthLane == 6'h00)
        else $error("Disabled fourth lane is driven.");
    a_cm_reset_low: assert property ($past(!reset_n) |->
        !cha_common_mode_select && !chb_common_mode_select)
        else $error("Common-mode select is not 1.2V after reset.");
    a_swing_reset_01: assert property ($past(!reset_n) |->
        cha_swing_select == 2'h1 && chb_swing_select == 2'h1)
        else $error("Swing select does not reset to 01.");
    a_odd_even_swap: assert property (channelMode == `LOFR_MODE_DUAL && inValidA &&
        !inValidB |=> ($past(pixelSwap) ? outLanesB.valid && !outLanesA.valid :
        outLanesA.valid && !outLanesB.valid))
        else $error("Odd pixel routed to the wrong channel.");
    a_stream_cross: assert property (channelMode == `LOFR_MODE_TWO_STREAM &&
        pixelSwap && inValidA |=> outLanesB.valid &&
        outLanesB.mainLanes[17:12] == ($past(chb_lsb_lane_select) ?
        $past(inPixelA.red[7:2]) : $past(inPixelA.red[5:0])))
        else $error("Stream A did not reach channel B.");
    a_single_b_idle: assert property (!bothInputs |=> !outLanesB.valid)
        else $error("Channel B active in single or reserved mode.");

    c_dual_swap:   cover property (channelMode == `LOFR_MODE_DUAL && pixelSwap && inValidA);
    c_stream_swap: cover property (channelMode == `LOFR_MODE_TWO_STREAM && crossed && inValidB);
    c_reduce:      cover property (srcValidA && cha_lsb_lane_select && !cha_fourth_lane_enable);
    c_write_done:  cover property (s_axi_bvalid && s_axi_bready);
endmodule : lofr_top
`default_nettype wire

/* File: testbench/lofr_panel_model.sv */
// Panel receiver model that counts the pixels arriving on each LVDS channel.
`timescale 1ns/1ps
`default_nettype none
module lofr_panel_model (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire lofr_pkg::lofr_lanes_s lanesA,
    input  wire lofr_pkg::lofr_lanes_s lanesB,
    output logic [15:0]                countA,
    output logic [15:0]                countB
);
    import lofr_pkg::*;
    // A panel latches only words flagged valid, so idle words must never count.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            countA <= 16'h0000;
            countB <= 16'h0000;
        end else begin
            countA <= countA + {15'h0000, lanesA.valid};
            countB <= countB + {15'h0000, lanesB.valid};
        end
    end
endmodule : lofr_panel_model
`default_nettype wire

/* File: testbench/lvds_output_format_routing_bench.sv */
// Self-checking bench for the LVDS format and routing block.
`include "lofr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lvds_output_format_routing_bench;
    import lofr_pkg::*;
    localparam logic [11:0] A_MODE = {`LOFR_IDX_MODE, 2'h0};
    localparam logic [11:0] A_FMT  = {`LOFR_IDX_FORMAT, 2'h0};
    localparam logic [11:0] A_LVL  = {`LOFR_IDX_LEVEL, 2'h0};
    localparam logic [11:0] A_SWAP = {`LOFR_IDX_SWAP, 2'h0};
    localparam logic [11:0] A_TRIM = {`LOFR_IDX_TRIM, 2'h0};
    localparam logic [23:0] P1     = 24'hC3A55A;
    localparam logic [23:0] P2     = 24'h3C5AA5;
    logic        clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, validA, validB, cmA, cmB;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, swA, swB, trA, trB;
    lofr_pixel_s pixA, pixB;
    lofr_lanes_s lanesA, lanesB;
    logic [15:0] rxA, rxB;
    int          errors, checked, sentA, sentB;

    lofr_top lofr_top_i (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .inPixelA(pixA), .inValidA(validA), .inPixelB(pixB),
        .inValidB(validB), .outLanesA(lanesA), .outLanesB(lanesB),
        .cha_common_mode_select(cmA), .chb_common_mode_select(cmB),
        .cha_swing_select(swA), .chb_swing_select(swB),
        .cha_common_mode_trim(trA), .chb_common_mode_trim(trB));
    lofr_panel_model lofr_panel_model_i (.clk(clk), .reset_n(reset_n), .lanesA(lanesA),
        .lanesB(lanesB), .countA(rxA), .countB(rxB));

    task automatic report_and_stop();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Each channel is released only at the edge that takes it, never earlier.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axi_write

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                check("rdata", exp, rdata);
                check("rresp", er, rresp);
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] resp;
        axi_write(a, {24'h000000, d}, 4'hF, resp);
        check("bresp", `LOFR_RESP_OKAY, resp);
    endtask : wr

    function automatic logic [24:0] lanes(input logic [23:0] p, input logic lsb, input logic en);
        logic [17:0] main;
        logic [5:0]  four;
        main = lsb ? {p[23:18], p[15:10], p[7:2]} : {p[21:16], p[13:8], p[5:0]};
        four = lsb ? {p[17:16], p[9:8], p[1:0]} : {p[23:22], p[15:14], p[7:6]};
        return {1'b1, main, en ? four : 6'h00};
    endfunction : lanes

    task automatic send(input logic [23:0] pa, input logic [23:0] pb, input logic [24:0] ea,
                        input logic [24:0] eb);
        @(posedge clk);
        pixA <= pa;
        pixB <= pb;
        validA <= 1'b1;
        validB <= 1'b1;
        @(posedge clk);
        validA <= 1'b0;
        validB <= 1'b0;
        #1;
        check("outLanesA", ea, lanesA);
        check("outLanesB", eb, lanesB);
        sentA += ea[24];
        sentB += eb[24];
    endtask : send

    task automatic test_reset();
        check("cha_swing_select", 32'h1, swA);
        check("chb_swing_select", 32'h1, swB);
        check("cha_common_mode_select", 32'h0, cmA);
        check("chb_common_mode_select", 32'h0, cmB);
        rd(A_LVL, 32'h05, `LOFR_RESP_OKAY);
        rd(A_MODE, 32'h20, `LOFR_RESP_OKAY);
        rd(A_FMT, 32'h00, `LOFR_RESP_OKAY);
        rd(A_SWAP, 32'h00, `LOFR_RESP_OKAY);
    endtask : test_reset

    task automatic test_format();
        logic [3:0] f;
        wr(A_MODE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            f = {i[1], ~i[1], i[0], ~i[0]};
            wr(A_FMT, {4'h0, f});
            rd(A_FMT, {28'h0, f}, `LOFR_RESP_OKAY);
            send(P1, P2, lanes(P1, f[1], f[3]), lanes(P2, f[0], f[2]));
        end
    endtask : test_format

    task automatic test_routing();
        wr(A_FMT, 8'h0F);
        for (int i = 0; i < 6; i++) begin
            wr(A_MODE, {1'b0, i[0], i >= 4, 5'h00});
            wr(A_SWAP, {1'b0, i == 2 || i == 3, 6'h00});
            if (i >= 4) send(P1, P2, lanes(P1, 1, 1), 25'h0);
            else if (i >= 2) send(P1, P2, lanes(P2, 1, 1), lanes(P1, 1, 1));
            else send(P1, P2, lanes(P1, 1, 1), lanes(P2, 1, 1));
        end
    endtask : test_routing

    // Only the odd-pixel input is valid, so a wrong swap shows as a pixel on the wrong channel.
    task automatic test_one_side();
        wr(A_MODE, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(A_SWAP, {1'b0, i[0], 6'h00});
            @(posedge clk);
            pixA <= P1;
            validA <= 1'b1;
            @(posedge clk);
            validA <= 1'b0;
            #1;
            check("outLanesA", (i == 0) ? lanes(P1, 1, 1) : 25'h0, lanesA);
            check("outLanesB", (i == 1) ? lanes(P1, 1, 1) : 25'h0, lanesB);
            sentA += (i == 0);
            sentB += (i == 1);
        end
    endtask : test_one_side

    task automatic test_levels();
        logic [1:0] resp;
        logic [7:0] v;
        wr(A_TRIM, 8'h11);
        check("cha_common_mode_trim", 32'h1, trA);
        check("chb_common_mode_trim", 32'h1, trB);
        for (int s = 0; s < 4; s++) begin
            v = {1'b0, s[0], 1'b0, ~s[0], s[1:0], ~s[1:0]};
            wr(A_LVL, v);
            rd(A_LVL, {24'h0, v}, `LOFR_RESP_OKAY);
            check("cha_common_mode_select", v[6], cmA);
            check("chb_common_mode_select", v[4], cmB);
            check("cha_swing_select", v[3:2], swA);
            check("chb_swing_select", v[1:0], swB);
        end
        axi_write(A_LVL, 32'h0, 4'hE, resp);
        check("bresp", `LOFR_RESP_OKAY, resp);
        rd(A_LVL, {24'h0, v}, `LOFR_RESP_OKAY);
        axi_write(12'h7FC, 32'hFF, 4'hF, resp);
        check("bresp", `LOFR_RESP_SLVERR, resp);
        rd(12'h7FC, 32'h0, `LOFR_RESP_SLVERR);
    endtask : test_levels

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready, validA, validB} = 8'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        pixA = 24'h000000;
        pixB = 24'h000000;
        errors = 0;
        checked = 0;
        sentA = 0;
        sentB = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        test_reset();
        test_format();
        test_routing();
        test_one_side();
        test_levels();
        repeat (2) @(posedge clk);
        check("panel count A", sentA, rxA);
        check("panel count B", sentB, rxB);
        report_and_stop();
    end

    // Tests need well under a thousand cycles; this span only catches a hung handshake.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule : lvds_output_format_routing_bench
`default_nettype wire
